// file: verilog/scar_consts.vh
// Register offsets, field positions, reset values and codes of the status/command bank
`ifndef SCAR_CONSTS_VH
`define SCAR_CONSTS_VH

// Byte addresses on the serial interface (low byte, high byte = +1)
`define SCAR_ADDR_DIAG        7'h3C
`define SCAR_ADDR_CMD_LO      7'h3E
`define SCAR_ADDR_CMD_HI      7'h3F
`define SCAR_ADDR_ALARM       7'h44
`define SCAR_ADDR_PEAK        7'h4A

// Reset values
`define SCAR_DIAG_RST         16'h0000
`define SCAR_ALARM_RST        16'h0000
`define SCAR_PEAK_RST         16'h0000

// Serial frame layout
`define SCAR_FRAME_BITS       16
`define SCAR_FRAME_WRITE_BIT  15
`define SCAR_ESCAPE_CODE      16'h00E8

// Diagnostic flag word bits
`define SCAR_DG_SUP_LOW       0
`define SCAR_DG_SUP_HIGH      1
`define SCAR_DG_FLASH_UPD     2
`define SCAR_DG_SPI_FAIL      3
`define SCAR_DG_ESCAPE        4
`define SCAR_DG_SELFTEST      5
`define SCAR_DG_FLASH_SUM     6
`define SCAR_DG_READY         7
`define SCAR_DG_SPEC_ALM1     10
`define SCAR_DG_SPEC_ALM2     13
`define SCAR_DG_SYS_ALM       14

// Global command word bits
`define SCAR_CMD_AUTONULL     0
`define SCAR_CMD_POWER_DOWN   1
`define SCAR_CMD_SELF_TEST    2
`define SCAR_CMD_FACTORY      3
`define SCAR_CMD_CLR_DIAG     4
`define SCAR_CMD_FLASH_TEST   5
`define SCAR_CMD_SAVE_REGS    6
`define SCAR_CMD_SW_RESET     7
`define SCAR_CMD_CLR_RECORDS  8
`define SCAR_CMD_ERASE_BANDS  9
`define SCAR_CMD_BUF_PTR_CLR  10
`define SCAR_CMD_REC_TOGGLE   11
`define SCAR_CMD_SAVE_BANDS   12
`define SCAR_CMD_LOAD_RECORD  13
`define SCAR_CMD_LOAD_BANDS   14
`define SCAR_CMD_CLR_NULL     15
// Commands finished inside this bank in one cycle
`define SCAR_CMD_LOCAL_MASK   16'h0812

// Alarm configuration bits
`define SCAR_CFG_LATCH        7
`define SCAR_CFG_NO_AUTOCLR   12

// Alarm status word fields
`define SCAR_ALM_FLAGS_LSB    4
`define SCAR_ALM_FLAGS_W      12
`define SCAR_ALM_BAND_W       3

`endif

// file: verilog/scar_spi.v
// Serial slave front end: pin synchronisers, 16-bit framing, shift-out and frame checks
`timescale 1ns/1ps
`default_nettype none
`include "scar_consts.vh"
module scar_spi (
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // Pins
    input  wire        cs_n_pin,
    input  wire        sclk_pin,
    input  wire        mosi_pin,
    output reg         miso,
    output wire        miso_oe,
    // Word side
    input  wire [15:0] tx_word,
    output reg  [15:0] rx_word,
    output reg         rx_valid,
    output reg         frame_err,
    output wire        cs_fall
);
    reg  [2:0]  sync1_reg;
    reg  [2:0]  sync2_reg;
    reg  [2:0]  prev_reg;
    reg  [3:0]  bit_cnt_reg;
    reg  [15:0] shift_in_reg;
    reg  [15:0] shift_out_reg;
    wire        cs_n;
    wire        sclk;
    wire        sclk_rise;
    wire        sclk_fall;
    wire        cs_rise;

    assign cs_n      = sync2_reg[2];
    assign sclk      = sync2_reg[1];
    assign sclk_rise = sclk & ~prev_reg[1] & ~cs_n;
    assign sclk_fall = ~sclk & prev_reg[1] & ~cs_n;
    assign cs_fall   = ~cs_n & prev_reg[2];
    assign cs_rise   = cs_n & ~prev_reg[2];
    assign miso_oe   = ~cs_n;

    // Edges are taken from the second stage only
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
            prev_reg  <= 3'h7;
        end else begin
            sync1_reg <= {cs_n_pin, sclk_pin, mosi_pin};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bit_cnt_reg   <= 4'h0;
            shift_in_reg  <= 16'h0000;
            shift_out_reg <= 16'h0000;
            rx_word       <= 16'h0000;
            rx_valid      <= 1'b0;
            frame_err     <= 1'b0;
            miso          <= 1'b0;
        end else begin
            rx_valid  <= 1'b0;
            frame_err <= 1'b0;
            if (cs_fall) begin
                bit_cnt_reg   <= 4'h0;
                shift_out_reg <= {tx_word[14:0], 1'b0};
                miso          <= tx_word[15];
            end else if (sclk_rise) begin
                shift_in_reg <= {shift_in_reg[14:0], sync2_reg[0]};
                bit_cnt_reg  <= bit_cnt_reg + 4'h1;
                if (bit_cnt_reg == 4'hF) begin
                    rx_word  <= {shift_in_reg[14:0], sync2_reg[0]};
                    rx_valid <= 1'b1;
                end
            end else if (sclk_fall) begin
                // Reload at each word boundary so frames may run back to back
                if (bit_cnt_reg == 4'h0) begin
                    miso          <= tx_word[15];
                    shift_out_reg <= {tx_word[14:0], 1'b0};
                end else begin
                    miso          <= shift_out_reg[15];
                    shift_out_reg <= {shift_out_reg[14:0], 1'b0};
                end
            end
            if (cs_rise && bit_cnt_reg != 4'h0) begin
                frame_err <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: verilog/scar_regs.v
// Status, global command and alarm result register bank behind the serial port
//
// What this block does
// - Diagnostic bit 7 shows one when data ready, zero while busy.
// - Diagnostic bit 6 set on flash checksum error, zero otherwise.
// - Command bit 2 runs self test; failure sets diagnostic bit 5.
// - Escape frame 0x00E8 sets diagnostic bit 4; next good recording clears it.
// - Diagnostic bit 3 set when a frame's clock count is not multiple of 16.
// - Diagnostic bit 1 set while supply is above 3.625 V.
// - Diagnostic bit 0 set while supply is below 2.975 V.
// - Diagnostic bit 14 set when system alarm threshold is crossed.
// - Spectral alarm 2 in bit 13, alarm 1 in bit 10; 8,9,11,12 reserved.
// - Host writes one to start a process; bit clears itself when done.
// - Command bit 0 runs autonull; bit 15 clears autonull correction.
// - Bits 14,13,12,9 load bands, load record, save bands, erase bands.
// - Command bit 11 toggles recording on and off.
// - Command bit 10 resets the buffer pointer to zero.
// - Bit 8 clears records, bit 7 software reset, bit 6 saves registers.
// - Command bit 5 runs the flash checksum test.
// - Command bit 4 clears the diagnostic flag word once.
// - Command bit 3 restores factory settings and empties capture buffers.
// - Command bit 1 sleeps; chip select toggle or timer wakes.
// - Alarm status bits 4..15 hold alarm 1/2 per band 1..6.
// - Alarm status bits 2:0 hold the most critical band number.
// - Alarm peak register holds the peak bin magnitude.
// - With latch option on, error flags hold until clear command.
// - Alarm status flags clear on read unless auto-clear is disabled.
`timescale 1ns/1ps
`default_nettype none
`include "scar_consts.vh"
module scar_regs (
    // Clock and reset
    input  wire        CLK_IN,
    input  wire        NRST_IN,
    // Serial pins
    input  wire        CS_N_IN,
    input  wire        SCLK_IN,
    input  wire        MOSI_IN,
    output wire        MISO_OUT,
    output wire        MISO_OE_OUT,
    // Core status
    input  wire        DATA_READY_IN,
    input  wire        SUPPLY_HIGH_IN,
    input  wire        SUPPLY_LOW_IN,
    input  wire        SYS_ALARM_IN,
    input  wire        FLASH_UPD_FAIL_IN,
    input  wire        REC_SUCCESS_IN,
    input  wire [15:0] ALARM_CONFIG_IN,
    // Test results
    input  wire        SELFTEST_DONE_IN,
    input  wire        SELFTEST_FAIL_IN,
    input  wire        FLASH_TEST_DONE_IN,
    input  wire        FLASH_TEST_FAIL_IN,
    // Alarm results
    input  wire        ALARM_UPDATE_IN,
    input  wire [11:0] ALARM_FLAGS_IN,
    input  wire [2:0]  ALARM_BAND_IN,
    input  wire [15:0] ALARM_PEAK_IN,
    // Command handshake
    output wire [15:0] CMD_REQ_OUT,
    input  wire [15:0] CMD_DONE_IN,
    output reg         RECORDING_OUT,
    output reg         SLEEP_OUT,
    input  wire        TIMER_WAKE_IN
);
    wire [15:0] rx_word;
    wire        rx_valid;
    wire        frame_err;
    wire        cs_fall;
    wire        is_write;
    wire [6:0]  addr;
    wire [7:0]  wdata;
    wire        escape_seen;
    wire        rd_alarm;
    wire        wr_cmd_lo;
    wire        wr_cmd_hi;
    wire        latch_on;
    wire        clr_diag;
    wire        spec_alm1;
    wire        spec_alm2;
    wire [5:0]  band_alm1;
    wire [5:0]  band_alm2;
    wire [15:0] cmd_set;
    wire [15:0] cmd_local;
    reg  [15:0] diag_word;
    reg  [15:0] cmd_pend_reg;
    reg  [15:0] cmd_pend_next;
    reg  [15:0] tx_reg;
    reg  [15:0] rd_mux;
    reg  [15:0] alarm_reg;
    reg  [15:0] alarm_next;
    reg  [15:0] peak_reg;
    reg         sup_low_reg;
    reg         sup_high_reg;
    reg         sys_alm_reg;
    reg         flash_upd_reg;
    reg         spi_fail_reg;
    reg         escape_reg;
    reg         selftest_reg;
    reg         flash_sum_reg;
    reg         ready_reg;
    reg         sup_low_next;
    reg         sup_high_next;
    reg         sys_alm_next;
    reg         flash_upd_next;
    reg         spi_fail_next;
    reg         escape_next;
    reg         selftest_next;
    reg         flash_sum_next;

    scar_spi u_spi (
        .clk       (CLK_IN),
        .nrst      (NRST_IN),
        .cs_n_pin  (CS_N_IN),
        .sclk_pin  (SCLK_IN),
        .mosi_pin  (MOSI_IN),
        .miso      (MISO_OUT),
        .miso_oe   (MISO_OE_OUT),
        .tx_word   (tx_reg),
        .rx_word   (rx_word),
        .rx_valid  (rx_valid),
        .frame_err (frame_err),
        .cs_fall   (cs_fall)
    );

    // Frame decode: write frames carry one byte, read frames name an address
    assign is_write    = rx_word[`SCAR_FRAME_WRITE_BIT];
    assign addr        = rx_word[14:8];
    assign wdata       = rx_word[7:0];
    assign escape_seen = rx_valid & (rx_word == `SCAR_ESCAPE_CODE);
    assign rd_alarm    = rx_valid & ~is_write & ({addr[6:1], 1'b0} == `SCAR_ADDR_ALARM);
    assign wr_cmd_lo   = rx_valid & is_write & (addr == `SCAR_ADDR_CMD_LO);
    assign wr_cmd_hi   = rx_valid & is_write & (addr == `SCAR_ADDR_CMD_HI);
    assign cmd_set     = {(wr_cmd_hi ? wdata : 8'h00), (wr_cmd_lo ? wdata : 8'h00)};
    assign cmd_local   = `SCAR_CMD_LOCAL_MASK;

    // Core-run processes are requested until the core reports them done
    assign CMD_REQ_OUT = cmd_pend_reg & ~cmd_local;
    assign clr_diag    = cmd_pend_reg[`SCAR_CMD_CLR_DIAG];
    assign latch_on    = ALARM_CONFIG_IN[`SCAR_CFG_LATCH];

    // Command bits self-clear: locally on the next cycle, else on the core's done
    always @* begin
        cmd_pend_next = cmd_pend_reg & ~cmd_local;
        cmd_pend_next = cmd_pend_next & ~CMD_DONE_IN;
        cmd_pend_next = cmd_pend_next | cmd_set;
    end

    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cmd_pend_reg <= 16'h0000;
        end else begin
            cmd_pend_reg <= cmd_pend_next;
        end
    end

    // Recording toggle and sleep control
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            RECORDING_OUT <= 1'b0;
            SLEEP_OUT     <= 1'b0;
        end else begin
            if (cmd_pend_reg[`SCAR_CMD_REC_TOGGLE]) begin
                RECORDING_OUT <= ~RECORDING_OUT;
            end
            // Wake wins over a sleep request arriving the same cycle
            if (cs_fall || TIMER_WAKE_IN) begin
                SLEEP_OUT <= 1'b0;
            end else if (cmd_pend_reg[`SCAR_CMD_POWER_DOWN]) begin
                SLEEP_OUT <= 1'b1;
            end
        end
    end

    // Diagnostic flags; a set in the clearing cycle always survives
    always @* begin
        // Level sources follow the core unless latched
        sup_low_next  = SUPPLY_LOW_IN | (latch_on & ~clr_diag & sup_low_reg);
        sup_high_next = SUPPLY_HIGH_IN | (latch_on & ~clr_diag & sup_high_reg);
        sys_alm_next  = SYS_ALARM_IN | (latch_on & ~clr_diag & sys_alm_reg);
        // Event sources are sticky until the clear command; escape also drops on a good recording
        flash_upd_next = FLASH_UPD_FAIL_IN | (~clr_diag & flash_upd_reg);
        spi_fail_next  = frame_err | (~clr_diag & spi_fail_reg);
        escape_next    = escape_reg & ~clr_diag & ~REC_SUCCESS_IN;
        if (escape_seen) begin
            escape_next = 1'b1;
        end
        // Test results are rewritten by each test; latch keeps a failure
        selftest_next = selftest_reg & ~clr_diag;
        if (SELFTEST_DONE_IN) begin
            selftest_next = SELFTEST_FAIL_IN | (latch_on & selftest_next);
        end
        flash_sum_next = flash_sum_reg & ~clr_diag;
        if (FLASH_TEST_DONE_IN) begin
            flash_sum_next = FLASH_TEST_FAIL_IN | (latch_on & flash_sum_next);
        end
    end

    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            sup_low_reg   <= 1'b0;
            sup_high_reg  <= 1'b0;
            sys_alm_reg   <= 1'b0;
            flash_upd_reg <= 1'b0;
            spi_fail_reg  <= 1'b0;
            escape_reg    <= 1'b0;
            selftest_reg  <= 1'b0;
            flash_sum_reg <= 1'b0;
            ready_reg     <= 1'b0;
        end else begin
            sup_low_reg   <= sup_low_next;
            sup_high_reg  <= sup_high_next;
            sys_alm_reg   <= sys_alm_next;
            flash_upd_reg <= flash_upd_next;
            spi_fail_reg  <= spi_fail_next;
            escape_reg    <= escape_next;
            selftest_reg  <= selftest_next;
            flash_sum_reg <= flash_sum_next;
            ready_reg     <= DATA_READY_IN;
        end
    end

    // Spectral alarm summaries: any band raising that alarm
    genvar band;
    generate
        for (band = 0; band < 6; band = band + 1) begin : g_band
            assign band_alm1[band] = alarm_reg[`SCAR_ALM_FLAGS_LSB + 2 * band];
            assign band_alm2[band] = alarm_reg[`SCAR_ALM_FLAGS_LSB + 2 * band + 1];
        end
    endgenerate
    assign spec_alm1 = |band_alm1;
    assign spec_alm2 = |band_alm2;

    // Reserved and unused diagnostic bits read as zero
    always @* begin
        diag_word                     = 16'h0000;
        diag_word[`SCAR_DG_SUP_LOW]   = sup_low_reg;
        diag_word[`SCAR_DG_SUP_HIGH]  = sup_high_reg;
        diag_word[`SCAR_DG_FLASH_UPD] = flash_upd_reg;
        diag_word[`SCAR_DG_SPI_FAIL]  = spi_fail_reg;
        diag_word[`SCAR_DG_ESCAPE]    = escape_reg;
        diag_word[`SCAR_DG_SELFTEST]  = selftest_reg;
        diag_word[`SCAR_DG_FLASH_SUM] = flash_sum_reg;
        diag_word[`SCAR_DG_READY]     = ready_reg;
        diag_word[`SCAR_DG_SPEC_ALM1] = spec_alm1;
        diag_word[`SCAR_DG_SPEC_ALM2] = spec_alm2;
        diag_word[`SCAR_DG_SYS_ALM]   = sys_alm_reg;
    end

    // Alarm results; an update in the read cycle is kept, not lost
    always @* begin
        alarm_next = alarm_reg;
        if (rd_alarm && !ALARM_CONFIG_IN[`SCAR_CFG_NO_AUTOCLR]) begin
            alarm_next[15:4] = 12'h000;
        end
        if (ALARM_UPDATE_IN) begin
            alarm_next[15:4] = alarm_next[15:4] | ALARM_FLAGS_IN;
            alarm_next[2:0]  = ALARM_BAND_IN;
        end
        alarm_next[3] = 1'b0;
    end

    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            alarm_reg <= `SCAR_ALARM_RST;
            peak_reg  <= `SCAR_PEAK_RST;
        end else begin
            alarm_reg <= alarm_next;
            if (ALARM_UPDATE_IN) begin
                peak_reg <= ALARM_PEAK_IN;
            end
        end
    end

    // Read data for the next frame; command word reads as zero
    always @* begin
        case ({addr[6:1], 1'b0})
            `SCAR_ADDR_DIAG:   rd_mux = diag_word;
            `SCAR_ADDR_ALARM:  rd_mux = alarm_reg;
            `SCAR_ADDR_PEAK:   rd_mux = peak_reg;
            default:           rd_mux = 16'h0000;
        endcase
    end

    // Reply is captured at the read frame, before any clear-on-read takes effect
    always @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            tx_reg <= 16'h0000;
        end else if (rx_valid && !is_write) begin
            tx_reg <= rd_mux;
        end
    end
endmodule
`default_nettype wire

// file: verification/scar_regs_assertions.sv
// Concurrent checks on the command handshake, record and sleep outputs
`timescale 1ns/1ps
`default_nettype none
`include "scar_consts.vh"
module scar_regs_chk (
    // Clock and reset
    input wire logic        CLK_IN,
    input wire logic        NRST_IN,
    // Watched ports
    input wire logic        CS_N_IN,
    input wire logic        TIMER_WAKE_IN,
    input wire logic [15:0] CMD_DONE_IN,
    input wire logic [15:0] CMD_REQ_OUT,
    input wire logic        RECORDING_OUT,
    input wire logic        SLEEP_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    // Eight idle cycles: no decoded word can still be in flight
    sequence s_quiet;
        CS_N_IN [*8];
    endsequence
    sequence s_done;
        s_quiet ##0 (CMD_DONE_IN != 16'h0000);
    endsequence
    a_local_no_req: assert property ((CMD_REQ_OUT & `SCAR_CMD_LOCAL_MASK) == 16'h0000)
        else $error("local command on request bus");
    a_req_holds: assert property (((~CMD_REQ_OUT) & $past(CMD_REQ_OUT) & ~$past(CMD_DONE_IN)) == 16'h0000)
        else $error("request dropped without done");
    a_done_clears: assert property (s_done |=> ((CMD_REQ_OUT & $past(CMD_DONE_IN)) == 16'h0000))
        else $error("request kept after done");
    a_no_spont_req: assert property (s_quiet |-> ((CMD_REQ_OUT & ~$past(CMD_REQ_OUT)) == 16'h0000))
        else $error("request raised without a frame");
    a_rec_steady: assert property (s_quiet |-> $stable(RECORDING_OUT))
        else $error("recording toggled without a frame");
    a_sleep_steady: assert property (s_quiet |-> !$rose(SLEEP_OUT))
        else $error("sleep entered without a frame");
    a_timer_wake: assert property (SLEEP_OUT && TIMER_WAKE_IN |-> ##[1:2] !SLEEP_OUT)
        else $error("timer did not wake");
    a_cs_wake: assert property (SLEEP_OUT && $fell(CS_N_IN) |-> ##[1:5] !SLEEP_OUT)
        else $error("chip select did not wake");
endmodule
bind scar_regs scar_regs_chk i_scar_regs_chk (.CLK_IN, .NRST_IN, .CS_N_IN, .TIMER_WAKE_IN,
    .CMD_DONE_IN, .CMD_REQ_OUT, .RECORDING_OUT, .SLEEP_OUT);
`default_nettype wire

// file: verification/scar_host.sv
// Host serial master model: mode 3, 16-bit words, MSB first
`timescale 1ns/1ps
`default_nettype none
module scar_host (
    // Clock
    input  wire logic clk_in,
    // Serial pins
    input  wire logic miso_in,
    output var logic  cs_n_out,
    output var logic  sclk_out,
    output var logic  mosi_out
);
    // Six cycles a half period keeps clear of the slave's pin synchronisers
    localparam int HALF = 6;
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b1;
        mosi_out = 1'b1;
    end
    // Sends n bits of w (n below 16 breaks framing on purpose), collects reply
    task automatic xfer(input int n, input logic [15:0] w, output logic [15:0] r);
        r = 16'h0000;
        @(posedge clk_in);
        cs_n_out <= 1'b0;
        repeat (HALF) @(posedge clk_in);
        for (int i = 0; i < n; i++) begin
            sclk_out <= 1'b0;
            mosi_out <= w[15-i];
            repeat (HALF) @(posedge clk_in);
            r = {r[14:0], miso_in};
            sclk_out <= 1'b1;
            repeat (HALF) @(posedge clk_in);
        end
        cs_n_out <= 1'b1;
        // Released data line must not keep a stale level
        mosi_out <= ~mosi_out;
        repeat (3*HALF) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// file: verification/scar_regs_tb.sv
// Self-checking bench for the status, command and alarm register bank
`timescale 1ns/1ps
`default_nettype none
`include "scar_consts.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module scar_regs_tb;
    localparam int LIMIT = 50000;
    int          cycles = 0, n_mismatch = 0, checked = 0;
    logic        clk = 0, nrst = 0, ready = 0, sup_hi = 0, sup_lo = 0, sys_alm = 0;
    logic        upd_fail = 0, rec_ok = 0, st_done = 0, st_fail = 0, ft_done = 0, ft_fail = 0;
    logic        alm_upd = 0, twake = 0;
    logic [15:0] cfg = 0, alarm_peak_level = 0, cmd_done = 0;
    logic [11:0] alm_flags = 0;
    logic [2:0]  alm_band = 0;
    wire logic   cs_n, sclk, mosi, miso, miso_oe, rec, slp;
    wire logic [15:0] cmd_req;
    // Released line shows the inverse of its last level
    wire logic   miso_bus = miso_oe ? miso : ~miso;

    always #2.5 clk = ~clk;

    scar_regs i_scar_regs (.CLK_IN(clk), .NRST_IN(nrst), .CS_N_IN(cs_n), .SCLK_IN(sclk), .MOSI_IN(mosi),
        .MISO_OUT(miso), .MISO_OE_OUT(miso_oe), .DATA_READY_IN(ready), .SUPPLY_HIGH_IN(sup_hi),
        .SUPPLY_LOW_IN(sup_lo), .SYS_ALARM_IN(sys_alm), .FLASH_UPD_FAIL_IN(upd_fail), .REC_SUCCESS_IN(rec_ok),
        .ALARM_CONFIG_IN(cfg), .SELFTEST_DONE_IN(st_done), .SELFTEST_FAIL_IN(st_fail),
        .FLASH_TEST_DONE_IN(ft_done), .FLASH_TEST_FAIL_IN(ft_fail), .ALARM_UPDATE_IN(alm_upd),
        .ALARM_FLAGS_IN(alm_flags), .ALARM_BAND_IN(alm_band), .ALARM_PEAK_IN(alarm_peak_level),
        .CMD_REQ_OUT(cmd_req), .CMD_DONE_IN(cmd_done), .RECORDING_OUT(rec), .SLEEP_OUT(slp),
        .TIMER_WAKE_IN(twake));
    scar_host i_scar_host (.clk_in(clk), .miso_in(miso_bus), .cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic [15:0] r;
        i_scar_host.xfer(16, {1'b1, a, v}, r);
    endtask
    // Reply arrives in the following word, so a dummy read of address 0 fetches it
    task automatic erd(input logic [6:0] a, input logic [15:0] e, input string nm);
        logic [15:0] r;
        logic [15:0] d;
        i_scar_host.xfer(16, {1'b0, a, 8'h00}, r);
        i_scar_host.xfer(16, 16'h0000, d);
        `CHK(nm, e, d)
    endtask
    task automatic fin(input string t);
        $display("test %s done, mismatches %0d", t, n_mismatch);
    endtask
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles >= LIMIT) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        logic [15:0] d;
        logic [15:0] m;
        tick(16);
        nrst <= 1'b1;
        tick(8);
        `CHK("oe_idle", 1'b0, miso_oe)
        wr(`SCAR_ADDR_PEAK, 8'h55);
        erd(`SCAR_ADDR_DIAG, 16'h0000, "diag_rst");
        erd(`SCAR_ADDR_ALARM, 16'h0000, "alarm_rst");
        erd(`SCAR_ADDR_PEAK, 16'h0000, "peak_ro");
        erd(`SCAR_ADDR_CMD_LO, 16'h0000, "cmd_wo");
        erd(7'h50, 16'h0000, "unmapped");
        fin("reset");
        {ready, sup_hi, sup_lo, sys_alm, upd_fail} <= 5'h1F;
        tick(1);
        upd_fail <= 1'b0;
        erd(`SCAR_ADDR_DIAG, 16'h4087, "diag_lvl");
        {ready, sup_hi, sup_lo, sys_alm} <= 4'h0;
        erd(`SCAR_ADDR_DIAG + 7'h01, 16'h0004, "diag_idle");
        i_scar_host.xfer(8, 16'h3C3C, d);
        erd(`SCAR_ADDR_DIAG, 16'h000C, "diag_frame");
        i_scar_host.xfer(16, `SCAR_ESCAPE_CODE, d);
        erd(`SCAR_ADDR_DIAG, 16'h001C, "diag_esc");
        wr(`SCAR_ADDR_CMD_LO, 8'h10);
        erd(`SCAR_ADDR_DIAG, 16'h0000, "diag_clr");
        i_scar_host.xfer(16, `SCAR_ESCAPE_CODE, d);
        rec_ok <= 1'b1;
        tick(1);
        rec_ok <= 1'b0;
        erd(`SCAR_ADDR_DIAG, 16'h0000, "esc_rec");
        fin("diag");
        {st_done, st_fail, ft_done, ft_fail} <= 4'hF;
        tick(1);
        {st_done, st_fail, ft_done, ft_fail} <= 4'h0;
        erd(`SCAR_ADDR_DIAG, 16'h0060, "test_fail");
        {st_done, ft_done} <= 2'h3;
        tick(1);
        {st_done, ft_done} <= 2'h0;
        erd(`SCAR_ADDR_DIAG, 16'h0000, "test_pass");
        cfg <= 16'h0080;
        sup_hi <= 1'b1;
        tick(2);
        sup_hi <= 1'b0;
        erd(`SCAR_ADDR_DIAG, 16'h0002, "latched");
        wr(`SCAR_ADDR_CMD_LO, 8'h10);
        erd(`SCAR_ADDR_DIAG, 16'h0000, "unlatch");
        cfg <= 16'h0000;
        fin("tests");
        for (int b = 0; b < 16; b++) begin
            m = 16'h0001 << b;
            wr(b < 8 ? `SCAR_ADDR_CMD_LO : `SCAR_ADDR_CMD_HI, b < 8 ? m[7:0] : m[15:8]);
            `CHK("cmd_req", m & ~`SCAR_CMD_LOCAL_MASK, cmd_req)
            cmd_done <= m;
            tick(1);
            cmd_done <= 16'h0000;
            tick(2);
            `CHK("cmd_self_clr", 16'h0000, cmd_req)
            if (b == 1) begin
                `CHK("sleep", 1'b1, slp)
                twake <= 1'b1;
                tick(1);
                twake <= 1'b0;
                tick(3);
                `CHK("timer_wake", 1'b0, slp)
            end
        end
        `CHK("rec_on", 1'b1, rec)
        wr(`SCAR_ADDR_CMD_HI, 8'h08);
        `CHK("rec_off", 1'b0, rec)
        wr(`SCAR_ADDR_CMD_LO, 8'h02);
        `CHK("sleep_again", 1'b1, slp)
        erd(`SCAR_ADDR_DIAG, 16'h0000, "diag_wake");
        `CHK("cs_wake", 1'b0, slp)
        fin("commands");
        for (int k = 0; k < 2; k++) begin
            {alm_upd, alm_flags, alm_band, alarm_peak_level} <= {1'b1, 12'hA05, 3'h3, 16'h1234};
            tick(1);
            alm_upd <= 1'b0;
            erd(`SCAR_ADDR_DIAG, 16'h2400, "diag_spec");
            erd(`SCAR_ADDR_ALARM, 16'hA053, "alarm");
            erd(`SCAR_ADDR_ALARM + 7'h01, k ? 16'hA053 : 16'h0003, "alarm_reread");
            erd(`SCAR_ADDR_PEAK, 16'h1234, "peak");
            cfg <= 16'h1000;
        end
        fin("alarm");
        close_out();
    end
endmodule
`default_nettype wire
